/* common/dsp_exec_pkg.sv */
// shared constants, field layouts and types of the execution block
package dsp_exec_pkg;
   // ==========================================================
   // status word bit positions
   localparam int SR_LF = 15; // loop active flag
   localparam int SR_PL_HIGH = 9; // priority level high bit
   localparam int SR_PL_LOW = 8; // priority level low bit
   localparam int SR_N = 3; // negative
   localparam int SR_Z = 2; // zero
   localparam int SR_V = 1; // overflow
   localparam int SR_C = 0; // carry
   localparam logic [15:0] SR_RESET = 16'h0000; // status word after reset
   // ==========================================================
   // destination codes of the any-register field
   localparam logic [4:0] DEST_STATUS_WORD = 5'h19; // status word
   localparam logic [4:0] DEST_HW_LOOP_STACK = 5'h1f; // hardware loop stack
   // ==========================================================
   // address forming for short forms
   localparam logic [9:0] SHORT_DATA_PAGE = 10'h000; // data page of 6-bit address
   localparam logic [9:0] SHORT_IO_PAGE = 10'h3ff; // peripheral page of 6-bit address
   localparam logic [15:0] RETURN_SKIP = 16'h0002; // second word after the fault op
   localparam logic [15:0] LC_STEP = 16'h0001; // loop counter decrement
   // ==========================================================
   // cycle counts, in clock cycles of the core clock
   localparam logic [1:0] XOR_PAD_CYCLES = 2'h2; // extra cycles of long forms
   localparam logic [1:0] FAULT_STEPS = 2'h3; // fault cycles after accept
   // ==========================================================
   // register bus byte offsets
   localparam logic [7:0] ADDR_STATUS_WORD = 8'h00;
   localparam logic [7:0] ADDR_LOOP_COUNTER = 8'h04;
   localparam logic [7:0] ADDR_ACC_A_LOW = 8'h08;
   localparam logic [7:0] ADDR_ACC_A_MID = 8'h0c;
   localparam logic [7:0] ADDR_ACC_A_EXT = 8'h10;
   localparam logic [7:0] ADDR_ACC_B_LOW = 8'h14;
   localparam logic [7:0] ADDR_ACC_B_MID = 8'h18;
   localparam logic [7:0] ADDR_ACC_B_EXT = 8'h1c;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h20;
   localparam logic [7:0] ADDR_INT_MASK = 8'h24;
   localparam logic [7:0] ADDR_SAVED_PC = 8'h28;
   localparam logic [7:0] ADDR_SAVED_SR = 8'h2c;
   // ==========================================================
   // interrupt status bits
   localparam int EV_XOR_DONE = 0;
   localparam int EV_FAULT_TAKEN = 1;
   localparam int EV_MUL_OVERFLOW = 2;
   localparam int EV_REFUSED = 3;
   localparam int EV_COUNT = 4;
   // ==========================================================
   // operation, form and sequencer types
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_XOR_IMMEDIATE = 2'h1,
      OP_FORCED_FAULT = 2'h2,
      OP_INTEGER_MULTIPLY = 2'h3
   } op_t;
   typedef enum logic [2:0] {
      FORM_REGISTER = 3'h0,
      FORM_SHORT_DATA = 3'h1,
      FORM_SHORT_IO = 3'h2,
      FORM_INDEXED_R2 = 3'h3,
      FORM_INDEXED_SP = 3'h4,
      FORM_LONG = 3'h5
   } form_t;
   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_PAD = 8'h02,
      ST_READ = 8'h04,
      ST_MODIFY = 8'h08,
      ST_WRITE = 8'h10,
      ST_DEFER = 8'h20,
      ST_FAULT = 8'h40,
      ST_MUL = 8'h80
   } state_t;
endpackage

/* common/mul_if.sv */
// operands and result between sequencer and multiplier
interface mul_if;
   logic [15:0] op_a; // first signed source
   logic [15:0] op_b; // second signed source
   logic [15:0] result; // low word of product
   logic overflow; // product does not fit 16 bits
   modport unit (input op_a, input op_b, output result, output overflow);
   modport core (output op_a, output op_b, input result, input overflow);
endinterface

/* core/dsp_xor_imm_fault_int_multiply.sv */
// execution unit for xor-immediate, forced fault and integer multiply
// What this block does
// - xor immediate into destination, write back
// - destination read once, then written once
// - executed as bit-field change, immediate masks
// - carry set when all masked bits one
// - status destination: only masked bits complement
// - hardware loop stack destination refused
// - 6-bit short addresses; 4 or 6 cycles
// - forced fault starts illegal-instruction exception
// - fault sets both priority level bits
// - loop end plus interrupted: counter decremented twice
// - fault deferred until repeat completes
// - return address is fault address plus two
// - fault: one word, 4 cycles, flags kept
// - signed multiply, low word to middle
// - no rounding, result sign-extended upward
// - multiply sets negative, zero, overflow flags
// - six source pairs only, 2 cycles
//
// The register addresses and strobed register access were decided locally.
module dsp_xor_imm_fault_int_multiply (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // issue port
   input wire logic issue_valid,
   output logic issue_ready,
   input wire logic [1:0] issue_op,
   input wire logic [2:0] issue_form,
   input wire logic [15:0] issue_imm,
   input wire logic [4:0] issue_dest,
   input wire logic [15:0] issue_addr,
   input wire logic [15:0] issue_pc,
   input wire logic [2:0] issue_pair,
   input wire logic issue_acc_b,
   input wire logic at_loop_last,
   input wire logic prev_interrupted,
   input wire logic repeat_active,
   output logic exec_done,
   // data-unit input registers
   input wire logic [15:0] du_x0,
   input wire logic [15:0] du_y0,
   input wire logic [15:0] du_y1,
   // data memory port
   output logic mem_rd,
   output logic mem_wr,
   output logic mem_io_space,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   // external register file port
   output logic dreg_rd,
   output logic dreg_wr,
   output logic [4:0] dreg_sel,
   output logic [15:0] dreg_wdata,
   input wire logic [15:0] dreg_rdata,
   // exception port
   output logic exc_vector_fetch,
   output logic [15:0] exc_return_addr,
   // register bus
   input wire logic [7:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [15:0] bus_rdata,
   output logic irq
);
   // ==========================================================
   // declarations
   dsp_exec_pkg::state_t state_q; // sequencer state
   logic [1:0] cnt_q; // step counter inside a state
   logic [15:0] imm_q; // mask of the xor op
   logic [2:0] form_q; // addressing form
   logic [4:0] dest_q; // register destination
   logic [15:0] ea_q; // effective address
   logic io_q; // short peripheral form
   logic [15:0] wdata_q; // modified word
   logic carry_q; // all-masked-bits-one test
   logic [15:0] fault_pc_q; // address of the fault op
   logic la_q; // fault op at loop end
   logic twice_q; // second decrement needed
   logic acc_b_q; // multiply destination is b
   logic [15:0] status_word_q; // status word
   logic [15:0] loop_counter_q; // loop counter
   logic [35:0] acc_a_q; // accumulator a
   logic [35:0] acc_b_reg_q; // accumulator b
   logic [15:0] saved_pc_q; // return address
   logic [15:0] saved_sr_q; // status at exception entry
   logic [dsp_exec_pkg::EV_COUNT-1:0] int_status_q; // sticky events
   logic [dsp_exec_pkg::EV_COUNT-1:0] int_mask_q; // event enables
   logic [dsp_exec_pkg::EV_COUNT-1:0] ev_set; // events this cycle
   logic [15:0] bus_rdata_q; // read answer
   logic [15:0] op_a_q; // multiply source a
   logic [15:0] op_b_q; // multiply source b
   logic accept; // issue taken this cycle
   logic is_reg_form; // register destination
   logic is_sr_dest; // status word destination
   logic refuse; // issue dropped
   logic pair_ok; // legal multiply pairing
   logic [15:0] pair_a; // selected first source
   logic [15:0] pair_b; // selected second source
   logic [15:0] old_word; // destination before change
   logic xor_wr; // xor write-back cycle
   logic mul_wr; // multiply write-back cycle
   logic fault_save; // fault entry cycle
   logic lc_dec; // loop counter step
   logic [35:0] mul_acc; // new accumulator value
   logic [15:0] mul_flags; // status word after multiply
   logic bus_sr_wr; // software write to status word

   mul_if mif ();

   int_multiply_unit u_mul (
      .m(mif)
   );

   assign mif.op_a = op_a_q;
   assign mif.op_b = op_b_q;

   // ==========================================================
   // issue decode
   assign issue_ready = (state_q == dsp_exec_pkg::ST_IDLE);
   assign accept = issue_valid & issue_ready & clk_en;
   assign is_reg_form = (issue_form == dsp_exec_pkg::FORM_REGISTER);
   assign is_sr_dest = (dest_q == dsp_exec_pkg::DEST_STATUS_WORD) &
                       (form_q == dsp_exec_pkg::FORM_REGISTER);

   // fixed source pairings of the multiply
   always_comb
   begin
      pair_ok = 1'b1;
      pair_a = du_y1;
      pair_b = du_x0;
      case (issue_pair)
         3'h0: begin pair_a = du_y1; pair_b = du_x0; end
         3'h1: begin pair_a = du_y0; pair_b = du_x0; end
         3'h2: begin pair_a = du_y1; pair_b = du_y0; end
         3'h3: begin pair_a = du_y0; pair_b = du_y0; end
         3'h4: begin pair_a = acc_a_q[31:16]; pair_b = du_y0; end
         3'h5: begin pair_a = acc_b_reg_q[31:16]; pair_b = du_y1; end
         default: pair_ok = 1'b0;
      endcase
   end

   // illegal destinations and pairings are dropped with an event
   always_comb
   begin
      refuse = 1'b0;
      case (issue_op)
         dsp_exec_pkg::OP_XOR_IMMEDIATE:
            refuse = is_reg_form & (issue_dest == dsp_exec_pkg::DEST_HW_LOOP_STACK);
         dsp_exec_pkg::OP_INTEGER_MULTIPLY:
            refuse = ~pair_ok;
         dsp_exec_pkg::OP_FORCED_FAULT:
            refuse = 1'b0;
         default:
            refuse = 1'b1; // no operation code
      endcase
   end

   // ==========================================================
   // sequencer
   // long and indexed forms spend two pad cycles on address forming
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q <= dsp_exec_pkg::ST_IDLE;
         cnt_q <= 2'h0;
      end
      else if (clk_en)
      begin
         case (state_q)
            dsp_exec_pkg::ST_IDLE:
               if (accept & ~refuse)
               begin
                  case (issue_op)
                     dsp_exec_pkg::OP_XOR_IMMEDIATE:
                        if (issue_form >= dsp_exec_pkg::FORM_INDEXED_R2)
                        begin
                           state_q <= dsp_exec_pkg::ST_PAD;
                           cnt_q <= dsp_exec_pkg::XOR_PAD_CYCLES;
                        end
                        else
                           state_q <= dsp_exec_pkg::ST_READ;
                     dsp_exec_pkg::OP_FORCED_FAULT:
                        if (repeat_active)
                           state_q <= dsp_exec_pkg::ST_DEFER;
                        else
                        begin
                           state_q <= dsp_exec_pkg::ST_FAULT;
                           cnt_q <= dsp_exec_pkg::FAULT_STEPS;
                        end
                     default:
                        state_q <= dsp_exec_pkg::ST_MUL;
                  endcase
               end
            dsp_exec_pkg::ST_PAD:
            begin
               cnt_q <= cnt_q - 2'h1;
               if (cnt_q == 2'h1)
                  state_q <= dsp_exec_pkg::ST_READ;
            end
            dsp_exec_pkg::ST_READ:
               state_q <= dsp_exec_pkg::ST_MODIFY;
            dsp_exec_pkg::ST_MODIFY:
               state_q <= dsp_exec_pkg::ST_WRITE;
            dsp_exec_pkg::ST_WRITE:
               state_q <= dsp_exec_pkg::ST_IDLE;
            dsp_exec_pkg::ST_DEFER:
               // repeat is uninterruptible: wait for it to end
               if (!repeat_active)
               begin
                  state_q <= dsp_exec_pkg::ST_FAULT;
                  cnt_q <= dsp_exec_pkg::FAULT_STEPS;
               end
            dsp_exec_pkg::ST_FAULT:
            begin
               cnt_q <= cnt_q - 2'h1;
               if (cnt_q == 2'h1)
                  state_q <= dsp_exec_pkg::ST_IDLE;
            end
            dsp_exec_pkg::ST_MUL:
               state_q <= dsp_exec_pkg::ST_IDLE;
            default:
               state_q <= dsp_exec_pkg::ST_IDLE;
         endcase
      end
   end

   // ==========================================================
   // captured context of the accepted op
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         imm_q <= 16'h0000;
         form_q <= 3'h0;
         dest_q <= 5'h00;
         ea_q <= 16'h0000;
         io_q <= 1'b0;
         fault_pc_q <= 16'h0000;
         la_q <= 1'b0;
         twice_q <= 1'b0;
         acc_b_q <= 1'b0;
         op_a_q <= 16'h0000;
         op_b_q <= 16'h0000;
      end
      else if (accept & ~refuse)
      begin
         imm_q <= issue_imm;
         form_q <= issue_form;
         dest_q <= issue_dest;
         io_q <= (issue_form == dsp_exec_pkg::FORM_SHORT_IO);
         // short forms carry only six address bits
         case (issue_form)
            dsp_exec_pkg::FORM_SHORT_DATA:
               ea_q <= {dsp_exec_pkg::SHORT_DATA_PAGE, issue_addr[5:0]};
            dsp_exec_pkg::FORM_SHORT_IO:
               ea_q <= {dsp_exec_pkg::SHORT_IO_PAGE, issue_addr[5:0]};
            default:
               ea_q <= issue_addr;
         endcase
         fault_pc_q <= issue_pc;
         la_q <= at_loop_last;
         twice_q <= at_loop_last & prev_interrupted;
         acc_b_q <= issue_acc_b;
         op_a_q <= pair_a;
         op_b_q <= pair_b;
      end
   end

   // ==========================================================
   // bit-field change datapath
   assign old_word = is_sr_dest ? status_word_q :
                     (form_q == dsp_exec_pkg::FORM_REGISTER) ? dreg_rdata : mem_rdata;

   // the read answer stands one cycle after the read strobe
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wdata_q <= 16'h0000;
         carry_q <= 1'b0;
      end
      else if (clk_en && state_q == dsp_exec_pkg::ST_MODIFY)
      begin
         wdata_q <= old_word ^ imm_q;
         carry_q <= &(old_word | ~imm_q);
      end
   end

   // strobes of the two destination accesses
   assign mem_rd = clk_en & (state_q == dsp_exec_pkg::ST_READ) &
                   (form_q != dsp_exec_pkg::FORM_REGISTER);
   assign mem_wr = clk_en & (state_q == dsp_exec_pkg::ST_WRITE) &
                   (form_q != dsp_exec_pkg::FORM_REGISTER);
   assign dreg_rd = clk_en & (state_q == dsp_exec_pkg::ST_READ) &
                    (form_q == dsp_exec_pkg::FORM_REGISTER) & ~is_sr_dest;
   assign dreg_wr = clk_en & (state_q == dsp_exec_pkg::ST_WRITE) &
                    (form_q == dsp_exec_pkg::FORM_REGISTER) & ~is_sr_dest;
   assign mem_io_space = io_q;
   assign mem_addr = ea_q;
   assign mem_wdata = wdata_q;
   assign dreg_sel = dest_q;
   assign dreg_wdata = wdata_q;

   assign xor_wr = clk_en & (state_q == dsp_exec_pkg::ST_WRITE);
   assign mul_wr = clk_en & (state_q == dsp_exec_pkg::ST_MUL);
   assign fault_save = clk_en & (state_q == dsp_exec_pkg::ST_FAULT) &
                       (cnt_q == dsp_exec_pkg::FAULT_STEPS);
   assign exec_done = xor_wr | mul_wr |
                      (clk_en & (state_q == dsp_exec_pkg::ST_FAULT) & (cnt_q == 2'h1));
   // vector fetched only after state was saved
   assign exc_vector_fetch = clk_en & (state_q == dsp_exec_pkg::ST_FAULT) &
                             (cnt_q == 2'h1);
   assign exc_return_addr = saved_pc_q;

   // ==========================================================
   // multiply result and flags
   always_comb
   begin
      mul_acc = acc_b_q ? acc_b_reg_q : acc_a_q;
      mul_acc[35:16] = {{4{mif.result[15]}}, mif.result};
      mul_flags = status_word_q;
      mul_flags[dsp_exec_pkg::SR_N] = mul_acc[35];
      mul_flags[dsp_exec_pkg::SR_Z] = ~(|mul_acc[35:16]);
      mul_flags[dsp_exec_pkg::SR_V] = mif.overflow;
   end

   // accumulators: low word is never touched by the multiply
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         acc_a_q <= 36'h000000000;
         acc_b_reg_q <= 36'h000000000;
      end
      else if (mul_wr)
      begin
         if (acc_b_q)
            acc_b_reg_q <= mul_acc;
         else
            acc_a_q <= mul_acc;
      end
   end

   // ==========================================================
   // status word; core updates win over a software write
   assign bus_sr_wr = bus_wr & (bus_addr == dsp_exec_pkg::ADDR_STATUS_WORD);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         status_word_q <= dsp_exec_pkg::SR_RESET;
      else if (clk_en)
      begin
         if (xor_wr & is_sr_dest)
            status_word_q <= status_word_q ^ imm_q;
         else if (xor_wr)
            status_word_q[dsp_exec_pkg::SR_C] <= carry_q;
         else if (mul_wr)
            status_word_q <= mul_flags;
         else if (fault_save)
         begin
            // only the priority bits change, flags stay
            status_word_q[dsp_exec_pkg::SR_PL_HIGH] <= 1'b1;
            status_word_q[dsp_exec_pkg::SR_PL_LOW] <= 1'b1;
         end
         else if (bus_sr_wr)
            status_word_q <= bus_wdata;
      end
   end

   // ==========================================================
   // exception entry: return point and status saved first
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         saved_pc_q <= 16'h0000;
         saved_sr_q <= 16'h0000;
      end
      else if (fault_save)
      begin
         saved_pc_q <= fault_pc_q + dsp_exec_pkg::RETURN_SKIP;
         saved_sr_q <= status_word_q;
      end
   end

   // ==========================================================
   // loop counter: one step at loop end, a second when interrupted
   assign lc_dec = clk_en & (state_q == dsp_exec_pkg::ST_FAULT) &
                   (((cnt_q == 2'h2) & la_q) | ((cnt_q == 2'h1) & twice_q));

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         loop_counter_q <= 16'h0000;
      else if (lc_dec)
         loop_counter_q <= loop_counter_q - dsp_exec_pkg::LC_STEP;
      else if (clk_en && bus_wr && bus_addr == dsp_exec_pkg::ADDR_LOOP_COUNTER)
         loop_counter_q <= bus_wdata;
   end

   // ==========================================================
   // interrupt events, sticky, write one to clear, set wins
   always_comb
   begin
      ev_set = '0;
      ev_set[dsp_exec_pkg::EV_XOR_DONE] = xor_wr;
      ev_set[dsp_exec_pkg::EV_FAULT_TAKEN] = fault_save;
      ev_set[dsp_exec_pkg::EV_MUL_OVERFLOW] = mul_wr & mif.overflow;
      ev_set[dsp_exec_pkg::EV_REFUSED] = accept & refuse;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         int_status_q <= '0;
         int_mask_q <= '0;
      end
      else if (clk_en)
      begin
         if (bus_wr && bus_addr == dsp_exec_pkg::ADDR_INT_STATUS)
            int_status_q <= (int_status_q & ~bus_wdata[dsp_exec_pkg::EV_COUNT-1:0]) | ev_set;
         else
            int_status_q <= int_status_q | ev_set;
         if (bus_wr && bus_addr == dsp_exec_pkg::ADDR_INT_MASK)
            int_mask_q <= bus_wdata[dsp_exec_pkg::EV_COUNT-1:0];
      end
   end

   assign irq = |(int_status_q & int_mask_q);

   // ==========================================================
   // register reads; unmapped offsets answer zero
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         bus_rdata_q <= 16'h0000;
      else if (clk_en)
      begin
         bus_rdata_q <= 16'h0000;
         if (bus_rd)
         begin
            case (bus_addr)
               dsp_exec_pkg::ADDR_STATUS_WORD: bus_rdata_q <= status_word_q;
               dsp_exec_pkg::ADDR_LOOP_COUNTER: bus_rdata_q <= loop_counter_q;
               dsp_exec_pkg::ADDR_ACC_A_LOW: bus_rdata_q <= acc_a_q[15:0];
               dsp_exec_pkg::ADDR_ACC_A_MID: bus_rdata_q <= acc_a_q[31:16];
               dsp_exec_pkg::ADDR_ACC_A_EXT: bus_rdata_q <= {12'h000, acc_a_q[35:32]};
               dsp_exec_pkg::ADDR_ACC_B_LOW: bus_rdata_q <= acc_b_reg_q[15:0];
               dsp_exec_pkg::ADDR_ACC_B_MID: bus_rdata_q <= acc_b_reg_q[31:16];
               dsp_exec_pkg::ADDR_ACC_B_EXT: bus_rdata_q <= {12'h000, acc_b_reg_q[35:32]};
               dsp_exec_pkg::ADDR_INT_STATUS: bus_rdata_q <= {12'h000, int_status_q};
               dsp_exec_pkg::ADDR_INT_MASK: bus_rdata_q <= {12'h000, int_mask_q};
               dsp_exec_pkg::ADDR_SAVED_PC: bus_rdata_q <= saved_pc_q;
               dsp_exec_pkg::ADDR_SAVED_SR: bus_rdata_q <= saved_sr_q;
               default: bus_rdata_q <= 16'h0000;
            endcase
         end
      end
   end

   assign bus_rdata = bus_rdata_q;
endmodule // dsp_xor_imm_fault_int_multiply

/* core/int_multiply_unit.sv */
// 16x16 signed integer multiplier with 16-bit result
module int_multiply_unit (
   mul_if.unit m
);
   // ==========================================================
   // product
   logic signed [31:0] product; // full signed product
   logic [16:0] top_bits; // bits that must match the sign of the result

   // signed multiply, no rounding and no saturation
   always_comb
   begin
      product = $signed(m.op_a) * $signed(m.op_b);
      top_bits = product[31:15];
   end

   assign m.result = product[15:0];
   // overflow when upper bits are not a pure sign extension
   assign m.overflow = ~((&top_bits) | ~(|top_bits));
endmodule // int_multiply_unit

/* tb/dsp_xor_imm_fault_int_multiply_asserts.sv */
// port-level checker for the execution block
module dsp_exec_checker (
   input wire logic clk, rst_b, clk_en, issue_valid, issue_ready, repeat_active,
   input wire logic exec_done, mem_rd, mem_wr, mem_io_space, exc_vector_fetch, dreg_wr,
   input wire logic [1:0] issue_op,
   input wire logic [2:0] issue_form, issue_pair,
   input wire logic [4:0] issue_dest,
   input wire logic [15:0] issue_pc, mem_addr, exc_return_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // accept strobe of the issue port
   wire logic acc = issue_valid && issue_ready && clk_en;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_rmw_order: assert property (mem_rd |=> !mem_wr ##1 mem_wr) else $error("write not 2 after read");
   a_short_four: assert property (acc && issue_op == 2'h1 && issue_form == 3'h1
      |=> !exec_done [*2] ##1 exec_done) else $error("short xor not 4 cycles");
   a_long_six: assert property (acc && issue_op == 2'h1 && issue_form == 3'h5
      |=> !exec_done [*4] ##1 exec_done) else $error("long xor not 6 cycles");
   a_io_page: assert property (mem_rd && mem_io_space |-> mem_addr[15:6] == 10'h3ff)
      else $error("io address off page");
   a_mul_two: assert property (acc && issue_op == 2'h3 && issue_pair < 3'h6 |=> exec_done)
      else $error("multiply not 2 cycles");
   a_fault_return: assert property (acc && issue_op == 2'h2 && !repeat_active
      |=> ##2 exc_vector_fetch && exc_return_addr == $past(issue_pc, 3) + 16'h0002)
      else $error("fault vector or return wrong");
   a_vector_done: assert property (exc_vector_fetch |-> exec_done) else $error("vector off end");
   a_defer_hold: assert property (repeat_active && !issue_ready |-> !exc_vector_fetch)
      else $error("fault taken during repeat");
   a_hws_refuse: assert property (acc && issue_op == 2'h1 && !issue_form
      && issue_dest == 5'h1f |=> issue_ready && !dreg_wr && !mem_wr)
      else $error("loop stack written");
endmodule // dsp_exec_checker
bind dsp_xor_imm_fault_int_multiply dsp_exec_checker i_dsp_exec_checker (.*);

/* tb/dsp_xor_imm_fault_int_multiply_tb.sv */
// self-checking bench of the execution block
module dsp_xor_imm_fault_int_multiply_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // stimulus and observed signals
   logic clk = 0, rst_b = 0, clk_en = 1, issue_valid = 0, issue_acc_b = 0, bus_wr = 0, bus_rd = 0;
   logic at_loop_last = 0, prev_interrupted = 0, repeat_active = 0;
   logic [1:0] issue_op = 0;
   logic [2:0] issue_form = 0, issue_pair = 0;
   logic [4:0] issue_dest = 0, dreg_sel;
   logic [7:0] bus_addr = 0;
   logic [15:0] issue_imm = 0, issue_addr = 0, issue_pc = 0, du_x0 = 0, du_y0 = 0, du_y1 = 0;
   logic [15:0] mem_rdata = 0, dreg_rdata = 0, bus_wdata = 0, n, wd;
   logic issue_ready, exec_done, mem_rd, mem_wr, mem_io_space, dreg_rd, dreg_wr, exc_vector_fetch;
   logic irq;
   logic [15:0] mem_addr, mem_wdata, dreg_wdata, exc_return_addr, bus_rdata;
   int errors = 0, num_checks = 0;
   dsp_xor_imm_fault_int_multiply i_dsp_xor_imm_fault_int_multiply (.*);
   initial forever #4 clk = ~clk;
   // read data valid only after a strobe, toggling otherwise so stale values match again only every second cycle
   always @(posedge clk) mem_rdata <= mem_rd ? 16'h5555 : ~mem_rdata;
   always @(posedge clk) dreg_rdata <= dreg_rd ? 16'h00f0 : ~dreg_rdata;
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk) {bus_addr, bus_wdata, bus_wr} <= {a, d, 1'b1};
      @(posedge clk) bus_wr <= 0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk) {bus_addr, bus_rd} <= {a, 1'b1};
      @(posedge clk) bus_rd <= 0;
      #1 chk(bus_rdata, e);
   endtask
   // one issue; n ends as the cycle index of the done pulse, wd keeps written data
   task automatic op(input logic [1:0] o, input logic [2:0] f, input logic [4:0] d,
      input logic [15:0] m, input logic [15:0] a);
      @(posedge clk) {issue_op, issue_form, issue_pair, issue_dest} <= {o, f, f, d};
      {issue_imm, issue_addr, issue_pc, issue_valid} <= {m, a, a, 1'b1};
      @(posedge clk) issue_valid <= 0;
      #1 n = 1;
      while (exec_done !== 1'b1 && n < 10)
      begin
         @(posedge clk) #1 n++;
         if (mem_wr === 1'b1) wd = mem_wdata;
         if (dreg_wr === 1'b1) wd = dreg_wdata;
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #100000 errors++;
      summarize();
   end
   // ==========================================================
   // scenarios
   task automatic t_xor();
      op(1, 1, 0, 16'h0ff0, 16'h0025); chk(n, 3); chk(wd, 16'h5aa5);
      rd(8'h00, 16'h0000);
      op(1, 2, 0, 16'h0505, 16'h0003); chk(wd, 16'h5050); rd(8'h00, 16'h0001);
      op(1, 5, 0, 16'hffff, 16'h1234); chk(n, 5); rd(8'h00, 16'h0000);
      op(1, 0, 5'h02, 16'h00ff, 0); chk(n, 3); chk(wd, 16'h000f);
      wr(8'h00, 0); op(1, 0, 5'h19, 16'h0006, 0); rd(8'h00, 16'h0006);
      wr(8'h20, 16'hffff); op(1, 0, 5'h1f, 16'h0001, 0); op(3, 6, 0, 0, 0);
      rd(8'h20, 16'h0008); rd(8'hfc, 0);
   endtask
   task automatic t_fault();
      wr(8'h00, 0); wr(8'h24, 16'h0002); wr(8'h04, 16'h0005);
      @(posedge clk) {at_loop_last, prev_interrupted} <= 2'h3;
      op(2, 0, 0, 0, 16'h0100); chk(n, 3); chk(exc_return_addr, 16'h0102);
      rd(8'h00, 16'h0300); rd(8'h04, 16'h0003); rd(8'h2c, 0);
      chk({15'h0, irq}, 16'h0001); wr(8'h20, 16'h0002); #1 chk({15'h0, irq}, 0);
      @(posedge clk) {at_loop_last, prev_interrupted, repeat_active} <= 3'h1;
      op(2, 0, 0, 0, 16'h0200); chk(n, 10);
      @(posedge clk) repeat_active <= 0;
      repeat (4) @(posedge clk);
      rd(8'h28, 16'h0202);
   endtask
   task automatic t_mul();
      @(posedge clk) {du_x0, du_y0, du_y1} <= {16'h0003, 16'h0004, 16'hffff};
      wr(8'h00, 0); op(3, 0, 0, 0, 0); chk(n, 1);
      rd(8'h0c, 16'hfffd); rd(8'h10, 16'h000f); rd(8'h00, 16'h0008);
      op(3, 1, 0, 0, 0); rd(8'h08, 0);
      rd(8'h0c, 16'h000c); rd(8'h10, 0); rd(8'h00, 0);
      @(posedge clk) {du_x0, issue_acc_b} <= {16'h4001, 1'b1};
      op(3, 1, 0, 0, 0); rd(8'h18, 16'h0004); rd(8'h0c, 16'h000c);
      rd(8'h00, 16'h0002); rd(8'h20, 16'h000e);
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      rst_b <= 1;
      t_xor();
      t_fault();
      t_mul();
      summarize();
   end
endmodule // dsp_xor_imm_fault_int_multiply_tb
